// ===== pmx_pkg.sv
// constants and types for the peripheral pin route multiplexer
package pmx_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned PMX_NPORT = 7;
  localparam int unsigned PMX_NPIN  = 8;
  localparam int unsigned PMX_NGRP  = 16;
  localparam int unsigned PMX_NSIG  = 4;
  localparam int unsigned PMX_AW    = 8;

  // ==========================================================
  // pin port indices
  localparam logic [2:0] PMX_PA = 3'h0;
  localparam logic [2:0] PMX_PB = 3'h1;
  localparam logic [2:0] PMX_PC = 3'h2;
  localparam logic [2:0] PMX_PD = 3'h3;
  localparam logic [2:0] PMX_PE = 3'h4;
  localparam logic [2:0] PMX_PF = 3'h5;
  localparam logic [2:0] PMX_PG = 3'h6;

  // ==========================================================
  // peripheral group indices (each group carries four signals)
  localparam int unsigned PMX_G_TABLE_ZERO_POSITION = 0;
  localparam int unsigned PMX_G_TABLE_THREE_POSITION = 3;
  localparam int unsigned PMX_G_TABLE_FIVE_POSITION = 5;
  localparam int unsigned PMX_G_SER0 = 6;
  localparam int unsigned PMX_G_SER2 = 8;
  localparam int unsigned PMX_G_SER5 = 11;
  localparam int unsigned PMX_G_SPI_ZERO_POSITION = 12;
  localparam int unsigned PMX_G_SPI_ONE_POSITION = 13;
  localparam int unsigned PMX_G_TWO_WIRE_ONE_POSITION = 14;
  localparam int unsigned PMX_G_EVA  = 15;
  localparam int unsigned PMX_SER_IN_A = 4;

  // home port of each lookup table and serial port, index 0 rightmost
  localparam logic [5:0][2:0] PMX_LUT_PORT = {PMX_PG, PMX_PB, PMX_PF, PMX_PD, PMX_PC, PMX_PA};
  localparam logic [5:0][2:0] PMX_SER_PORT = {PMX_PG, PMX_PE, PMX_PB, PMX_PF, PMX_PC, PMX_PA};

  // ==========================================================
  // pin positions inside a port
  localparam logic [2:0] PMX_LUT_OUT_DEF = 3'h3;
  localparam logic [2:0] PMX_LUT_OUT_ALT = 3'h6;
  localparam logic [2:0] PMX_HI_NIBBLE   = 3'h4;
  localparam logic [2:0] PMX_TWI_LO      = 3'h2;
  localparam logic [2:0] PMX_TWI_HI      = 3'h6;
  localparam logic [2:0] PMX_EVA_DEF     = 3'h2;
  localparam logic [2:0] PMX_EVA_ALT     = 3'h7;

  // ==========================================================
  // field selector codes
  localparam logic [1:0] PMX_SEL_DEFAULT = 2'h0;
  localparam logic [1:0] PMX_SEL_ALTERNATE_ONE    = 2'h1;
  localparam logic [1:0] PMX_SEL_ALTERNATE_TWO    = 2'h2;
  localparam logic [1:0] PMX_SEL_NONE    = 2'h3;

  // ==========================================================
  // register indices (byte address = 4 * index), masks, resets
  localparam logic [5:0] PMX_IDX_EVT   = 6'h00;
  localparam logic [5:0] PMX_IDX_LUT   = 6'h01;
  localparam logic [5:0] PMX_IDX_SER_A = 6'h02;
  localparam logic [5:0] PMX_IDX_SER_B = 6'h03;
  localparam logic [5:0] PMX_IDX_SPI   = 6'h04;
  localparam logic [5:0] PMX_IDX_TWI   = 6'h05;
  localparam logic [7:0] PMX_MSK_EVT   = 8'h01;
  localparam logic [7:0] PMX_MSK_LUT   = 8'h3F;
  localparam logic [7:0] PMX_MSK_SER_A = 8'hFF;
  localparam logic [7:0] PMX_MSK_SER_B = 8'h0F;
  localparam logic [7:0] PMX_MSK_SPI   = 8'h0F;
  localparam logic [7:0] PMX_MSK_TWI   = 8'h0C;
  localparam logic [7:0] PMX_REG_RST   = 8'h00;
  localparam int unsigned PMX_SPI_ONE_POSITION_LSB = 2;
  localparam int unsigned PMX_TWO_WIRE_ONE_POSITION_LSB = 2;

  // ==========================================================
  // bus responses
  localparam logic [1:0] PMX_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PMX_RESP_SLVERR = 2'h2;

  // ==========================================================
  // types
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } pmx_drv_t;

  typedef struct packed {
    logic       ok;
    logic [2:0] port;
    logic [2:0] pos;
  } pmx_loc_t;

  typedef struct packed {
    logic [7:0] evt;
    logic [7:0] lut;
    logic [7:0] ser_a;
    logic [7:0] ser_b;
    logic [7:0] spi;
    logic [7:0] twi;
  } pmx_regs_t;

  typedef struct packed {
    pmx_regs_t            regs;
    logic [6:0][7:0]      sync1;
    logic [6:0][7:0]      sync2;
    logic [6:0][7:0]      pin_o;
    logic [6:0][7:0]      pin_oe;
    logic [15:0][3:0]     per_in;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic                 aw_got;
    logic                 w_got;
    logic [5:0]           aw_idx;
    logic [7:0]           wbyte;
    logic                 wlane;
  } pmx_state_t;

  localparam pmx_state_t PMX_STATE_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                           default: '0};

endpackage

// ===== pmx_route.sv
// peripheral pin route multiplexer with its AXI4-Lite register slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module pmx_route
  import pmx_pkg::*;
(
  // clock and reset
  input  wire logic                             CLK,
  input  wire logic                             NRST,
  // register bus write address
  input  wire logic [pmx_pkg::PMX_AW-1:0]       AWADDR,
  input  wire logic                             AWVALID,
  output var  logic                             AWREADY,
  // register bus write data
  input  wire logic [31:0]                      WDATA,
  input  wire logic [3:0]                       WSTRB,
  input  wire logic                             WVALID,
  output var  logic                             WREADY,
  // register bus write response
  output var  logic [1:0]                       BRESP,
  output var  logic                             BVALID,
  input  wire logic                             BREADY,
  // register bus read address
  input  wire logic [pmx_pkg::PMX_AW-1:0]       ARADDR,
  input  wire logic                             ARVALID,
  output var  logic                             ARREADY,
  // register bus read data
  output var  logic [31:0]                      RDATA,
  output var  logic [1:0]                       RRESP,
  output var  logic                             RVALID,
  input  wire logic                             RREADY,
  // peripheral side
  input  wire pmx_pkg::pmx_drv_t [15:0]         PERIPH_DRV,
  output var  logic [15:0][3:0]                 PERIPH_IN,
  // pin side
  input  wire logic [6:0][7:0]                  PIN_IN,
  output var  logic [6:0][7:0]                  PIN_OUT,
  output var  logic [6:0][7:0]                  PIN_OE
);

  // ==========================================================
  // state
  pmx_state_t q;
  pmx_state_t d;

  // ==========================================================
  // helpers
  function automatic pmx_loc_t mk(input logic ok, input logic [2:0] p, input logic [2:0] b);
    pmx_loc_t l;
    l.ok   = ok;
    l.port = p;
    l.pos  = b;
    return l;
  endfunction

  // pin location of signal s of group g under the current register values
  function automatic pmx_loc_t route_of(input int unsigned g, input int unsigned s,
                                        input pmx_regs_t r);
    pmx_loc_t    l;
    logic [1:0]  f;
    logic [2:0]  s3;
    logic [2:0]  p;
    int unsigned k;
    l  = '0;
    f  = PMX_SEL_DEFAULT;
    s3 = s[2:0];
    p  = PMX_PA;
    k  = 0;
    if (g <= PMX_G_TABLE_FIVE_POSITION) begin
      k = g - PMX_G_TABLE_ZERO_POSITION;
      p = PMX_LUT_PORT[k];
      if (r.lut[k] && g == PMX_G_TABLE_THREE_POSITION) begin
        l = '0;
      end else if (s == 3) begin
        l = mk(1'b1, p, r.lut[k] ? PMX_LUT_OUT_ALT : PMX_LUT_OUT_DEF);
      end else begin
        l = mk(1'b1, p, s3);
      end
    end else if (g <= PMX_G_SER5) begin
      k = g - PMX_G_SER0;
      p = PMX_SER_PORT[k];
      if (k < PMX_SER_IN_A) begin
        f = r.ser_a[2*k +: 2];
      end else begin
        f = r.ser_b[2*(k-PMX_SER_IN_A) +: 2];
      end
      case (f)
        PMX_SEL_DEFAULT: l = mk(1'b1, p, s3);
        PMX_SEL_ALTERNATE_ONE: begin
          if (g == PMX_G_SER2 && s >= 2) begin
            l = '0;
          end else begin
            l = mk(1'b1, p, s3 + PMX_HI_NIBBLE);
          end
        end
        default: l = '0;
      endcase
    end else if (g == PMX_G_SPI_ZERO_POSITION) begin
      f = r.spi[1:0];
      case (f)
        PMX_SEL_DEFAULT: l = mk(1'b1, PMX_PA, s3 + PMX_HI_NIBBLE);
        PMX_SEL_ALTERNATE_ONE:    l = mk(1'b1, PMX_PE, s3);
        PMX_SEL_ALTERNATE_TWO:    l = mk(1'b1, PMX_PG, s3 + PMX_HI_NIBBLE);
        default:         l = '0;
      endcase
    end else if (g == PMX_G_SPI_ONE_POSITION) begin
      f = r.spi[PMX_SPI_ONE_POSITION_LSB +: 2];
      case (f)
        PMX_SEL_DEFAULT: l = mk(1'b1, PMX_PC, s3);
        PMX_SEL_ALTERNATE_ONE:    l = mk(1'b1, PMX_PC, s3 + PMX_HI_NIBBLE);
        PMX_SEL_ALTERNATE_TWO:    l = mk(1'b1, PMX_PB, s3 + PMX_HI_NIBBLE);
        default:         l = '0;
      endcase
    end else if (g == PMX_G_TWO_WIRE_ONE_POSITION) begin
      f = r.twi[PMX_TWO_WIRE_ONE_POSITION_LSB +: 2];
      // signals 0,1 are host/client pair, 2,3 the dual-mode client pair
      if (s < 2) begin
        case (f)
          PMX_SEL_DEFAULT,
          PMX_SEL_ALTERNATE_ONE: l = mk(1'b1, PMX_PF, PMX_TWI_LO + {2'h0, s3[0]});
          PMX_SEL_ALTERNATE_TWO: l = mk(1'b1, PMX_PB, PMX_TWI_LO + {2'h0, s3[0]});
          default:      l = '0;
        endcase
      end else begin
        case (f)
          PMX_SEL_DEFAULT: l = mk(1'b1, PMX_PB, PMX_TWI_LO + {2'h0, s3[0]});
          PMX_SEL_ALTERNATE_ONE,
          PMX_SEL_ALTERNATE_TWO:    l = mk(1'b1, PMX_PB, PMX_TWI_HI + {2'h0, s3[0]});
          default:         l = '0;
        endcase
      end
    end else if (s == 0) begin
      l = mk(1'b1, PMX_PA, r.evt[0] ? PMX_EVA_ALT : PMX_EVA_DEF);
    end
    return l;
  endfunction

  function automatic logic idx_ok(input logic [5:0] idx);
    return idx <= PMX_IDX_TWI;
  endfunction

  function automatic logic [7:0] reg_read(input logic [5:0] idx, input pmx_regs_t r);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      PMX_IDX_EVT:   v = r.evt;
      PMX_IDX_LUT:   v = r.lut;
      PMX_IDX_SER_A: v = r.ser_a;
      PMX_IDX_SER_B: v = r.ser_b;
      PMX_IDX_SPI:   v = r.spi;
      PMX_IDX_TWI:   v = r.twi;
      default:       v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    pmx_loc_t loc;
    loc = '0;
    d   = q;

    // two-stage pin synchroniser
    d.sync1 = PIN_IN;
    d.sync2 = q.sync1;

    // routing; of two groups driving one pin, the later group wins
    d.pin_o  = '0;
    d.pin_oe = '0;
    d.per_in = '0;
    for (int unsigned g = 0; g < PMX_NGRP; g++) begin
      for (int unsigned s = 0; s < PMX_NSIG; s++) begin
        loc = route_of(g, s, q.regs);
        if (loc.ok) begin
          d.per_in[g][s] = q.sync2[loc.port][loc.pos];
          if (PERIPH_DRV[g].oe[s]) begin
            d.pin_o[loc.port][loc.pos]  = PERIPH_DRV[g].o[s];
            d.pin_oe[loc.port][loc.pos] = 1'b1;
          end
        end
      end
    end

    // write address and data, taken in either order
    if (AWVALID && q.awready) begin
      d.aw_got  = 1'b1;
      d.aw_idx  = AWADDR[7:2];
      d.awready = 1'b0;
    end
    if (WVALID && q.wready) begin
      d.w_got  = 1'b1;
      d.wbyte  = WDATA[7:0];
      d.wlane  = WSTRB[0];
      d.wready = 1'b0;
    end

    // write once both halves are held
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = idx_ok(q.aw_idx) ? PMX_RESP_OKAY : PMX_RESP_SLVERR;
      if (q.wlane) begin
        case (q.aw_idx)
          PMX_IDX_EVT:   d.regs.evt   = q.wbyte & PMX_MSK_EVT;
          PMX_IDX_LUT:   d.regs.lut   = q.wbyte & PMX_MSK_LUT;
          PMX_IDX_SER_A: d.regs.ser_a = q.wbyte & PMX_MSK_SER_A;
          PMX_IDX_SER_B: d.regs.ser_b = q.wbyte & PMX_MSK_SER_B;
          PMX_IDX_SPI:   d.regs.spi   = q.wbyte & PMX_MSK_SPI;
          PMX_IDX_TWI:   d.regs.twi   = q.wbyte & PMX_MSK_TWI;
          default:       d.regs       = q.regs;
        endcase
      end
    end
    if (q.bvalid && BREADY) begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end

    // read
    if (ARVALID && q.arready) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rdata   = {24'h000000, reg_read(ARADDR[7:2], q.regs)};
      d.rresp   = idx_ok(ARADDR[7:2]) ? PMX_RESP_OKAY : PMX_RESP_SLVERR;
    end
    if (q.rvalid && RREADY) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      q <= PMX_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign AWREADY   = q.awready;
  assign WREADY    = q.wready;
  assign BVALID    = q.bvalid;
  assign BRESP     = q.bresp;
  assign ARREADY   = q.arready;
  assign RVALID    = q.rvalid;
  assign RRESP     = q.rresp;
  assign RDATA     = q.rdata;
  assign PERIPH_IN = q.per_in;
  assign PIN_OUT   = q.pin_o;
  assign PIN_OE    = q.pin_oe;

endmodule

`default_nettype wire

// ===== pmx_route_sva.sv
// checker for the pin route multiplexer
`timescale 1ns/1ps
`default_nettype none
module pmx_route_sva
  import pmx_pkg::*;
(
  // clock and reset
  input wire logic                       CLK,
  input wire logic                       NRST,
  // register bus
  input wire logic [pmx_pkg::PMX_AW-1:0] AWADDR,
  input wire logic                       AWVALID,
  input wire logic                       AWREADY,
  input wire logic [31:0]                WDATA,
  input wire logic [3:0]                 WSTRB,
  input wire logic                       WVALID,
  input wire logic                       WREADY,
  input wire logic [1:0]                 BRESP,
  input wire logic                       BVALID,
  input wire logic [pmx_pkg::PMX_AW-1:0] ARADDR,
  input wire logic                       ARVALID,
  input wire logic                       ARREADY,
  input wire logic [31:0]                RDATA,
  input wire logic [1:0]                 RRESP,
  input wire logic                       RVALID,
  // pins and peripherals
  input wire pmx_pkg::pmx_drv_t [15:0]   PERIPH_DRV,
  input wire logic [15:0][3:0]           PERIPH_IN,
  input wire logic [6:0][7:0]            PIN_IN,
  input wire logic [6:0][7:0]            PIN_OE
);
  localparam logic [7:0][7:0] MSK = {16'h0, PMX_MSK_TWI, PMX_MSK_SPI, PMX_MSK_SER_B,
                                     PMX_MSK_SER_A, PMX_MSK_LUT, PMX_MSK_EVT};
  logic [5:0]      aw_q;
  logic [5:0]      ar_q;
  logic [7:0]      wd_q;
  logic            ws_q;
  logic            bv_q;
  logic [7:0][7:0] sh;
  // ==========================================================
  // shadow of the route registers, one cycle behind the design
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      aw_q <= '0;
      ar_q <= '0;
      wd_q <= '0;
      ws_q <= 1'b0;
      bv_q <= 1'b0;
      sh <= '0;
    end else begin
      bv_q <= BVALID;
      if (AWVALID && AWREADY) aw_q <= AWADDR[7:2];
      if (ARVALID && ARREADY) ar_q <= ARADDR[7:2];
      if (WVALID && WREADY) wd_q <= WDATA[7:0];
      if (WVALID && WREADY) ws_q <= WSTRB[0];
      if (BVALID && !bv_q && ws_q && aw_q <= 6'h05) sh[aw_q[2:0]] <= wd_q & MSK[aw_q[2:0]];
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  sequence s_wr_take;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_wr_ans;
    !BVALID && !AWREADY ##1 BVALID;
  endsequence
  property p_wr_lat;
    s_wr_take |=> s_wr_ans;
  endproperty
  property p_rd_lat;
    ARVALID && ARREADY |=> RVALID && !ARREADY;
  endproperty
  property p_wr_resp;
    $rose(BVALID) |-> BRESP == (aw_q > 6'h05 ? PMX_RESP_SLVERR : PMX_RESP_OKAY);
  endproperty
  property p_rd_data;
    $rose(RVALID) |-> RDATA == {24'h0, (ar_q > 6'h05 ? 8'h00 : sh[ar_q[2:0]])}
      && RRESP == (ar_q > 6'h05 ? PMX_RESP_SLVERR : PMX_RESP_OKAY);
  endproperty
  // pin drive needs one settled cycle out of reset
  property p_evt;
    $past(NRST) && $past(PERIPH_DRV[15].oe[0]) |-> PIN_OE[0][sh[0][0] ? 7 : 2];
  endproperty
  property p_twi;
    $past(NRST) && $past(PERIPH_DRV[14].oe[0]) && sh[5][3:2] != 2'h3 |->
      PIN_OE[sh[5][3] ? 1 : 5][2];
  endproperty
  property p_twi_dual;
    $past(NRST) && $past(PERIPH_DRV[14].oe[3]) && sh[5][3:2] != 2'h3 |->
      PIN_OE[1][sh[5][3:2] == 2'h0 ? 3 : 7];
  endproperty
  // the synchroniser refills for three cycles after reset
  property p_ser0_in;
    $past(NRST) && $past(NRST, 2) && $past(NRST, 3) |->
      PERIPH_IN[6][1] == (sh[2][1:0] == 2'h0 ? $past(PIN_IN[0][1], 3) :
                          sh[2][1:0] == 2'h1 ? $past(PIN_IN[0][5], 3) : 1'b0);
  endproperty
  property p_ser2_cut;
    sh[2][5:4] != 2'h0 |-> PERIPH_IN[8][3:2] == 2'h0;
  endproperty
  property p_table_three_position_cut;
    sh[1][3] |-> PERIPH_IN[3] == 4'h0;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer timing wrong");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer timing wrong");
  a_wr_resp: assert property (p_wr_resp) else $error("write response wrong");
  a_rd_data: assert property (p_rd_data) else $error("read data wrong");
  a_evt: assert property (p_evt) else $error("event output pin wrong");
  a_twi: assert property (p_twi) else $error("two-wire data pin wrong");
  a_twi_dual: assert property (p_twi_dual) else $error("two-wire dual clock pin wrong");
  a_ser0_in: assert property (p_ser0_in) else $error("serial zero receive wrong");
  a_ser2_cut: assert property (p_ser2_cut) else $error("serial two clock not cut");
  a_table_three_position_cut: assert property (p_table_three_position_cut) else $error("table three not cut");
endmodule

bind pmx_route pmx_route_sva pmx_route_sva_i (.CLK(CLK), .NRST(NRST), .AWADDR(AWADDR),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
  .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .ARADDR(ARADDR), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
  .PERIPH_DRV(PERIPH_DRV), .PERIPH_IN(PERIPH_IN), .PIN_IN(PIN_IN), .PIN_OE(PIN_OE));
`default_nettype wire

// ===== pmx_route_tb_top.sv
// self-checking bench for the pin route multiplexer
`timescale 1ns/1ps
`default_nettype none
module pmx_route_tb_top;
  import pmx_pkg::*;
  // row: register, value, group, signal, port (7 = none), pin, peripheral drives
  typedef struct packed {
    logic [3:0] idx;
    logic [7:0] val;
    logic [3:0] grp;
    logic [3:0] sig;
    logic [3:0] port;
    logic [3:0] pin;
    logic [3:0] out;
  } pmx_row_t;
  localparam pmx_row_t ROWS [29] = '{
    32'h0_01_F_0_0_7_1, 32'h0_00_F_0_0_2_1,
    32'h1_20_5_3_6_6_1, 32'h1_10_4_3_1_6_1,
    32'h1_08_3_3_7_0_1, 32'h1_00_3_0_5_0_0,
    32'h1_04_2_3_3_6_1, 32'h1_02_1_3_2_6_1,
    32'h1_01_0_3_0_6_1, 32'h2_7F_9_3_1_7_1,
    32'h2_DF_8_1_5_5_0, 32'h2_DF_8_2_7_0_1,
    32'h2_F7_7_2_2_6_1, 32'h2_FD_6_0_0_4_1,
    32'h2_FE_6_0_7_0_1, 32'h3_07_B_3_6_7_1,
    32'h3_0D_A_1_4_5_0, 32'h4_0B_D_0_1_4_1,
    32'h4_0F_D_0_7_0_1, 32'h4_0E_C_1_6_5_0,
    32'h4_0D_C_2_4_2_1, 32'h4_0C_C_3_0_7_1,
    32'h5_08_E_0_1_2_1, 32'h5_04_E_3_1_7_1,
    32'h2_00_6_1_0_1_0, 32'h2_3F_6_0_7_0_1,
    32'h2_00_8_3_5_3_1, 32'h5_00_E_2_1_2_1,
    32'h5_0C_E_0_7_0_1};
  localparam logic [5:0][7:0] MSK = {PMX_MSK_TWI, PMX_MSK_SPI, PMX_MSK_SER_B,
                                     PMX_MSK_SER_A, PMX_MSK_LUT, PMX_MSK_EVT};
  logic                         CLK, NRST;
  logic [pmx_pkg::PMX_AW-1:0]   AWADDR, ARADDR;
  logic [31:0]                  WDATA, RDATA;
  logic [3:0]                   WSTRB;
  logic [1:0]                   BRESP, RRESP;
  logic                         AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic                         ARVALID, ARREADY, RVALID, RREADY;
  pmx_pkg::pmx_drv_t [15:0]     PERIPH_DRV;
  logic [15:0][3:0]             PERIPH_IN;
  logic [6:0][7:0]              PIN_IN, PIN_OUT, PIN_OE;
  int                           n_mismatch;
  int                           checks;

  pmx_route pmx_route_i (.CLK(CLK), .NRST(NRST), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .PERIPH_DRV(PERIPH_DRV), .PERIPH_IN(PERIPH_IN), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE));

  always #5 CLK = ~CLK;

  // ==========================================================
  // checks and bus tasks
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic tmo(input string nm);
    n_mismatch++;
    $display("[FAIL] %s expected answer seen none", nm);
    stop_test();
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic s,
                    input logic [1:0] r);
    int i;
    // one edge between transfers so no strobe is set twice in a time step
    @(posedge CLK);
    AWADDR <= {a, 2'h0};
    WDATA <= {24'h0, d};
    WSTRB <= {4{s}};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    BREADY <= 1'b0;
    if (i == 50) tmo("bvalid");
    chk("bresp", BRESP, r);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [1:0] r);
    int i;
    @(posedge CLK);
    ARADDR <= {a, 2'h0};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    RREADY <= 1'b0;
    if (i == 50) tmo("rvalid");
    chk("rdata", RDATA, {24'h0, e});
    chk("rresp", RRESP, r);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    pmx_row_t         row;
    pmx_drv_t [15:0]  drv;
    logic [55:0]      pin;
    {n_mismatch, checks, CLK, NRST, AWADDR, ARADDR, WDATA, WSTRB} = '0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, PERIPH_DRV, PIN_IN} = '0;
    repeat (20) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    chk("reset pin_oe", PIN_OE, 56'h0);
    for (int k = 0; k < 6; k++) begin
      rd(k[5:0], 8'h00, PMX_RESP_OKAY);
      wr(k[5:0], 8'hFF, 1'b1, PMX_RESP_OKAY);
      rd(k[5:0], MSK[k], PMX_RESP_OKAY);
    end
    wr(PMX_IDX_SER_A, 8'h00, 1'b0, PMX_RESP_OKAY);
    rd(PMX_IDX_SER_A, 8'hFF, PMX_RESP_OKAY);
    wr(6'h06, 8'hFF, 1'b1, PMX_RESP_SLVERR);
    rd(6'h06, 8'h00, PMX_RESP_SLVERR);
    $display("register test done");
    foreach (ROWS[r]) begin
      row = ROWS[r];
      wr({2'h0, row.idx}, row.val, 1'b1, PMX_RESP_OKAY);
      drv = '0;
      if (row.out[0]) begin
        drv[row.grp].o[row.sig] = 1'b1;
        drv[row.grp].oe[row.sig] = 1'b1;
      end
      pin = (row.port == 4'h7) ? 56'h0 : 56'h1 << (row.port * 8 + row.pin);
      PERIPH_DRV <= drv;
      PIN_IN <= (row.port == 4'h7) ? '1 : pin;
      repeat (4) @(posedge CLK);
      chk("pin_oe", PIN_OE, row.out[0] ? pin : 56'h0);
      chk("pin_out", PIN_OUT, row.out[0] ? pin : 56'h0);
      chk("periph_in", PERIPH_IN[row.grp][row.sig], row.port != 4'h7);
      $display("row %0d done", r);
    end
    // mid-run reset while a peripheral still drives and every pin is high
    NRST <= 1'b0;
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    chk("reset pin_oe", PIN_OE, 56'h0);
    @(posedge CLK);
    chk("default two-wire pin_oe", PIN_OE, 56'h1 << (PMX_PF * 8 + PMX_TWI_LO));
    chk("default two-wire pin_out", PIN_OUT, 56'h1 << (PMX_PF * 8 + PMX_TWI_LO));
    for (int k = 0; k < 6; k++) begin
      rd(k[5:0], 8'h00, PMX_RESP_OKAY);
    end
    $display("reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
